// ===== verification/serial_peripheral_model.sv
// Behavioural external peripheral that answers the port in controller mode
`timescale 1ns/1ps
module serial_peripheral_model (
  // Clock
  input wire logic i_ref_clk,
  // Serial side
  input wire logic i_sclk,
  input wire logic i_sel_n,
  input wire logic i_mosi,
  output logic o_miso,
  // Word setup
  input wire logic i_pol,
  input wire logic i_phase,
  input wire logic [4:0] i_len,
  input wire logic [15:0] i_tx,
  output logic [15:0] o_rx
);
  logic sclk_r = 1'b0;
  logic sel_r = 1'b1;
  int idx = 0;
  wire lead = (sclk_r == i_pol) && (i_sclk != i_pol);
  wire trail = (sclk_r != i_pol) && (i_sclk == i_pol);
  initial o_miso = 1'b0;
  initial o_rx = 16'h0000;
  // clock from the port, one bit each way per period
  // Sampling between port edges lets a reply settle before the next port edge
  always @(negedge i_ref_clk) begin
    sclk_r <= i_sclk;
    sel_r <= i_sel_n;
    if (sel_r && !i_sel_n) begin
      idx = i_len - 1;
      o_rx <= 16'h0000;
      if (!i_phase) o_miso <= i_tx[idx];
    end else if (i_sel_n) begin
      // Released line keeps changing so stale data cannot pass for a match
      o_miso <= ~o_miso;
    end else if (lead) begin
      if (i_phase) o_miso <= i_tx[idx];
      else o_rx <= {o_rx[14:0], i_mosi};
    end else if (trail) begin
      if (i_phase) o_rx <= {o_rx[14:0], i_mosi};
      idx = (idx == 0) ? i_len - 1 : idx - 1;
      if (!i_phase) o_miso <= i_tx[idx];
    end
  end
endmodule : serial_peripheral_model

// ===== verification/tb.sv
// Self-checking bench for the multibuffered serial port in controller mode, peripheral mode and general purpose pin use
`timescale 1ns/1ps
module tb;
  import serial_port_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [FMT_NUM-1:0][FMT_W-1:0] fmt = '0;
  logic [7:0] c2t = 8'h00, t2c = 8'h00;
  logic [GRP_NUM-1:0][ADDR_W-1:0] grp_first = '0, grp_last = '0;
  logic [3:0] grp_trig = 4'h0, host_we = 4'h0;
  logic [7:0] host_addr = 8'h00;
  logic [63:0] host_wdata = 64'h0, host_rdata;
  logic busy, grp_done, rx_valid, sclk_o, sclk_oe_n, cout_o, cout_oe_n, cin_o, cin_oe_n, sel_o, sel_oe_n, miso;
  logic [1:0] act_grp;
  logic [15:0] rx_buf, m_rx, m_tx = 16'h0000, rx_got = 16'h0000;
  logic [3:0] gpio_en = 4'h0, gpio_out = 4'h0, gpio_oe_n = 4'hF, gpio_in;
  logic m_pol = 1'b0, m_ph = 1'b0, sclk_p = 1'b0, sel_p = 1'b1, rxv_seen = 1'b0;
  logic [4:0] m_len = 5'h02;
  logic ctrl_en = 1'b1, ext_sclk = 1'b0, ext_mosi = 1'b0, ext_sel_n = 1'b1;
  int lens[4] = '{2, 16, 9, 5};
  int pss[4] = '{0, 255, 5, 7};
  int cyc = 0, t_sel = 0, t_first = -1, t_lead = 0, per = 0, t_trail = 0, hold_len = 0, sel_falls = 0;
  int failures = 0, total_checks = 0;
  // Lines the port leaves undriven carry the bench controller or the peer
  wire sclk_w = sclk_oe_n ? ext_sclk : sclk_o;
  wire cout_w = cout_oe_n ? ext_mosi : cout_o;
  wire cin_w = cin_oe_n ? miso : cin_o;
  wire sel_w = sel_oe_n ? ext_sel_n : sel_o;
  initial forever #2 ref_clk = ~ref_clk;
  multibuffered_serial_port dut (.i_ref_clk(ref_clk), .i_nrst(nrst), .i_controller_en(ctrl_en),
    .i_word_format_register(fmt), .i_select_to_clock_delay(c2t), .i_clock_to_select_delay(t2c),
    .i_grp_first(grp_first), .i_grp_last(grp_last), .i_grp_trig(grp_trig), .i_host_we(host_we),
    .i_host_addr(host_addr), .i_host_wdata(host_wdata), .o_host_rdata(host_rdata), .o_busy(busy),
    .o_active_grp(act_grp), .o_grp_done(grp_done), .o_rx_buffer(rx_buf), .o_rx_valid(rx_valid),
    .i_serial_clock_pin(sclk_w), .o_serial_clock_pin(sclk_o), .o_serial_clock_pin_oe_n(sclk_oe_n),
    .i_controller_out_line(cout_w), .o_controller_out_line(cout_o), .o_controller_out_line_oe_n(cout_oe_n),
    .i_controller_in_line(cin_w), .o_controller_in_line(cin_o), .o_controller_in_line_oe_n(cin_oe_n),
    .i_select_n_pin(sel_w), .o_select_n_pin(sel_o), .o_select_n_pin_oe_n(sel_oe_n),
    .i_gpio_en(gpio_en), .i_gpio_out(gpio_out), .i_gpio_oe_n(gpio_oe_n), .o_gpio_in(gpio_in));
  serial_peripheral_model peer (.i_ref_clk(ref_clk), .i_sclk(sclk_w), .i_sel_n(sel_w), .i_mosi(cout_w),
    .o_miso(miso), .i_pol(m_pol), .i_phase(m_ph), .i_len(m_len), .i_tx(m_tx), .o_rx(m_rx));
  ////////////////////////////////////////////////////////////////////////
  // Pin monitor: frame timing in clock cycles
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    sclk_p <= sclk_w;
    sel_p <= sel_w;
    if (sel_p && !sel_w) begin
      t_sel <= cyc;
      t_first <= -1;
      per <= 0;
      rxv_seen <= 1'b0;
      sel_falls <= sel_falls + 1;
    end
    if (!sel_w && sclk_p == m_pol && sclk_w != m_pol) begin
      if (t_first < 0) t_first <= cyc - t_sel;
      else if (per == 0) per <= cyc - t_lead;
      t_lead <= cyc;
    end
    if (sclk_p != m_pol && sclk_w == m_pol) t_trail <= cyc;
    if (!sel_p && sel_w) hold_len <= cyc - t_trail;
    if (rx_valid === 1'b1) begin
      rxv_seen <= 1'b1;
      rx_got <= rx_buf;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chkn(input string what, input int exp, input int got);
    total_checks++;
    if (got != exp) begin
      failures++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask : chkn
  task automatic host_write(input logic [7:0] a, input logic [3:0] we, input logic [63:0] d);
    @(posedge ref_clk);
    host_addr <= a;
    host_we <= we;
    host_wdata <= d;
    @(posedge ref_clk);
    host_we <= 4'h0;
  endtask : host_write
  task automatic host_read(input logic [7:0] a, output logic [63:0] d);
    @(posedge ref_clk);
    host_addr <= a;
    @(posedge ref_clk);
    #1;
    d = host_rdata;
  endtask : host_read
  task automatic run_grp(input int g, input logic [7:0] a, input logic [7:0] b);
    int n;
    n = 0;
    @(posedge ref_clk);
    grp_first[g] <= a;
    grp_last[g] <= b;
    grp_trig[g] <= 1'b1;
    @(posedge ref_clk);
    grp_trig <= 4'h0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (grp_done !== 1'b1 && n < 30000);
    if (n >= 30000) begin
      failures++;
      $display("unexpected group_done: expected 1 seen %b", grp_done);
      final_report();
    end
    chk("active_group", 16'(g), 16'(act_grp));
  endtask : run_grp
  task automatic run_word(input int f, input logic [7:0] e, input logic hold);
    logic [15:0] tx, mask;
    logic [63:0] d;
    int p;
    tx = 16'hC35A ^ {8'h00, e};
    mask = 16'((32'h1 << lens[f]) - 1);
    p = (pss[f] == 0) ? 2 : pss[f] + 1;
    m_pol = f[0];
    m_ph = f[1];
    m_len = 5'(lens[f]);
    m_tx = ~tx;
    @(posedge ref_clk);
    fmt[f] <= {f[0], f[1], 8'(pss[f]), 3'h0, 5'(lens[f])};
    c2t <= 8'(f);
    t2c <= 8'(3 - f);
    host_write(e, 4'hF, {16'h0000, 13'h0000, hold, 2'(f), 16'h0000, tx});
    run_grp(1, e, e);
    host_read(e, d);
    chk("peer_rx", tx & mask, m_rx & mask);
    chk("rx_buffer", ~tx & mask, rx_got);
    chk("rx_field", ~tx & mask, d[31:16]);
    chk("status_field", STAT_DONE, d[63:48]);
    chk("rx_valid", 16'h0001, {15'h0000, rxv_seen});
    chkn("setup", f + (hold ? 3 : 2), t_first);
    chkn("period", p, per);
    chkn("select_hold", p - p / 2 + 3 - f + 1, hold_len);
    chk("clock_idle", {15'h0000, m_pol}, {15'h0000, sclk_w});
    $display("test word format %0d done", f);
  endtask : run_word
  // Bench plays the external controller; the port runs as peripheral
  task automatic ext_word(input logic [7:0] e, input logic [7:0] tx, input logic [7:0] sent);
    logic [7:0] got;
    logic [63:0] d;
    int n;
    n = 0;
    got = 8'h00;
    @(posedge ref_clk);
    ctrl_en <= 1'b0;
    fmt[0] <= {2'b00, 8'h00, 3'h0, 5'h08};
    host_write(e, 4'hF, {48'h0, 8'h00, tx});
    @(posedge ref_clk);
    grp_first[3] <= e;
    grp_last[3] <= e;
    grp_trig[3] <= 1'b1;
    @(posedge ref_clk);
    grp_trig <= 4'h0;
    repeat (8) @(posedge ref_clk);
    ext_sel_n <= 1'b0;
    ext_mosi <= sent[7];
    repeat (4) @(posedge ref_clk);
    // One bit each way per clock period, phase 0
    for (int i = 7; i >= 0; i--) begin
      got[i] = cin_w;
      ext_sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      ext_sclk <= 1'b0;
      if (i > 0) ext_mosi <= sent[i - 1];
      repeat (4) @(posedge ref_clk);
    end
    while (busy !== 1'b0 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n >= 100) begin
      failures++;
      $display("unexpected busy: expected 0 seen %b", busy);
      final_report();
    end
    @(posedge ref_clk);
    ext_sel_n <= 1'b1;
    host_read(e, d);
    chk("ext_line_out", {8'h00, tx}, {8'h00, got});
    chk("ext_rx_buffer", {8'h00, sent}, rx_got);
    chk("ext_rx_valid", 16'h0001, {15'h0000, rxv_seen});
    chk("ext_rx_field", {8'h00, sent}, d[31:16]);
    chk("ext_status", STAT_DONE | STAT_PERIPH, d[63:48]);
    chk("ext_line_release", 16'h0001, {15'h0000, cin_oe_n});
    $display("test peripheral mode done");
  endtask : ext_word
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [63:0] d;
    int n0;
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk("busy", 16'h0000, {15'h0000, busy});
    chk("select_idle", 16'h0001, {15'h0000, sel_w});
    chk("rx_buffer", 16'h0000, rx_buf);
    $display("test reset done");
    host_write(8'hFF, 4'hF, 64'h4444_3333_2222_1111);
    host_write(8'hFF, 4'h2, 64'h0000_0000_ABCD_0000);
    host_read(8'hFF, d);
    chk("entry_tx", 16'h1111, d[15:0]);
    chk("entry_rx", 16'hABCD, d[31:16]);
    chk("entry_ctrl", 16'h3333, d[47:32]);
    chk("entry_status", 16'h4444, d[63:48]);
    $display("test buffer memory done");
    for (int f = 0; f < 4; f++) run_word(f, 8'(f + 1), f == 2);
    n0 = sel_falls;
    for (int i = 0; i < 3; i++) host_write(8'(20 + i), 4'hF, {16'h0000, 13'h0, i == 0, 2'h3, 32'h0000_1234});
    run_grp(2, 8'h14, 8'h16);
    chkn("select_frames", 2, sel_falls - n0);
    host_read(8'h16, d);
    chk("last_status", STAT_DONE, d[63:48]);
    $display("test group done");
    ext_word(8'h30, 8'hA5, 8'h3C);
    for (int v = 1; v >= 0; v--) begin
      @(posedge ref_clk);
      gpio_en <= 4'h4;
      gpio_oe_n <= 4'hB;
      gpio_out <= {1'b0, 1'(v), 2'h0};
      repeat (3) @(posedge ref_clk);
      #1;
      chk("gpio_oe_n", 16'h0000, {15'h0000, cin_oe_n});
      chk("gpio_in", 16'(v), {15'h0000, gpio_in[PIN_CIN]});
    end
    $display("test general purpose pin done");
    final_report();
  end
endmodule : tb

// ===== verilog/buffer_ram.sv
// Multibuffer memory: entries of four halfword fields, two ports
`timescale 1ns/1ps
module buffer_ram (
  // Clock
  input wire logic i_ref_clk,
  // Port A, host side
  input wire logic [serial_port_pkg::FIELD_NUM-1:0] i_a_we,
  input wire logic [serial_port_pkg::ADDR_W-1:0] i_a_addr,
  input wire logic [serial_port_pkg::ENTRY_W-1:0] i_a_wdata,
  output logic [serial_port_pkg::ENTRY_W-1:0] o_a_rdata,
  // Port B, transfer engine side
  input wire logic [serial_port_pkg::FIELD_NUM-1:0] i_b_we,
  input wire logic [serial_port_pkg::ADDR_W-1:0] i_b_addr,
  input wire logic [serial_port_pkg::ENTRY_W-1:0] i_b_wdata,
  output logic [serial_port_pkg::ENTRY_W-1:0] o_b_rdata
);
  import serial_port_pkg::*;

  logic [ENTRY_W-1:0] mem [0:ENTRIES-1];

  // Engine write comes last so it wins a same-field collision
  always_ff @(posedge i_ref_clk) begin
    for (int f = 0; f < FIELD_NUM; f++) begin
      if (i_a_we[f]) begin
        mem[i_a_addr][f*WORD_W +: WORD_W] <= i_a_wdata[f*WORD_W +: WORD_W];
      end
      if (i_b_we[f]) begin
        mem[i_b_addr][f*WORD_W +: WORD_W] <= i_b_wdata[f*WORD_W +: WORD_W];
      end
    end
    o_a_rdata <= mem[i_a_addr];
    o_b_rdata <= mem[i_b_addr];
  end
endmodule : buffer_ram

// ===== verilog/multibuffered_serial_port.sv
// Multibuffered serial port: group sequencer, shifter, baud timing, pins
`timescale 1ns/1ps
module multibuffered_serial_port (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Configuration
  input wire logic i_controller_en,
  input wire logic [serial_port_pkg::FMT_NUM-1:0][serial_port_pkg::FMT_W-1:0] i_word_format_register,
  input wire logic [serial_port_pkg::DLY_W-1:0] i_select_to_clock_delay,
  input wire logic [serial_port_pkg::DLY_W-1:0] i_clock_to_select_delay,
  // Transfer groups
  input wire logic [serial_port_pkg::GRP_NUM-1:0][serial_port_pkg::ADDR_W-1:0] i_grp_first,
  input wire logic [serial_port_pkg::GRP_NUM-1:0][serial_port_pkg::ADDR_W-1:0] i_grp_last,
  input wire logic [serial_port_pkg::GRP_NUM-1:0] i_grp_trig,
  // Host access to the multibuffer
  input wire logic [serial_port_pkg::FIELD_NUM-1:0] i_host_we,
  input wire logic [serial_port_pkg::ADDR_W-1:0] i_host_addr,
  input wire logic [serial_port_pkg::ENTRY_W-1:0] i_host_wdata,
  output logic [serial_port_pkg::ENTRY_W-1:0] o_host_rdata,
  // Status
  output logic o_busy,
  output logic [serial_port_pkg::GRP_W-1:0] o_active_grp,
  output logic o_grp_done,
  output logic [serial_port_pkg::WORD_W-1:0] o_rx_buffer,
  output logic o_rx_valid,
  // Serial pins
  input wire logic i_serial_clock_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_clock_pin_oe_n,
  input wire logic i_controller_out_line,
  output logic o_controller_out_line,
  output logic o_controller_out_line_oe_n,
  input wire logic i_controller_in_line,
  output logic o_controller_in_line,
  output logic o_controller_in_line_oe_n,
  input wire logic i_select_n_pin,
  output logic o_select_n_pin,
  output logic o_select_n_pin_oe_n,
  // General purpose use of the pins
  input wire logic [serial_port_pkg::PIN_NUM-1:0] i_gpio_en,
  input wire logic [serial_port_pkg::PIN_NUM-1:0] i_gpio_out,
  input wire logic [serial_port_pkg::PIN_NUM-1:0] i_gpio_oe_n,
  output logic [serial_port_pkg::PIN_NUM-1:0] o_gpio_in
);
  import serial_port_pkg::*;

  state_t st_r, st_nxt;
  logic [ADDR_W-1:0] idx_r, last_r;
  logic [GRP_W-1:0] grp_r, pick_w;
  logic [GRP_NUM-1:0] pend_r;
  logic [FMT_W-1:0] fmt_r;
  logic hold_r, out_r, cap_r, sclk_r, sel_n_r, sin_r, sin_prev_r, rxv_r, gdone_r;
  logic [WORD_W-1:0] sh_r, rxb_r;
  logic [CNT_W-1:0] cnt_r;
  logic [BIT_W-1:0] bit_r;
  logic [ENTRY_W-1:0] ram_rd;
  logic [PIN_NUM-1:0] pin_in, func_out, func_oe_n, pin_out, pin_oe_n, gpio_in_r;

  function automatic logic [BIT_W-1:0] len_of(input logic [FMT_W-1:0] f);
    logic [BIT_W-1:0] l;
    l = f[FMT_LEN_LSB +: FMT_LEN_W];
    len_of = (l < LEN_MIN) ? LEN_MIN : ((l > LEN_MAX) ? LEN_MAX : l);
  endfunction : len_of

  ////////////////////////////////////////////////////////////////////////////
  // Format decode and timing counts
  wire ctrl = i_controller_en;
  wire [WORD_W-1:0] tx_w = ram_rd[FLD_TX*WORD_W +: WORD_W];
  wire [WORD_W-1:0] ctl_w = ram_rd[FLD_CTRL*WORD_W +: WORD_W];
  wire [FMT_W-1:0] new_fmt = i_word_format_register[ctl_w[CTL_FSEL_LSB +: FMT_SEL_W]];
  wire [BIT_W-1:0] new_len = len_of(new_fmt);
  wire [WORD_W-1:0] ld_w = tx_w << (LEN_MAX - new_len);
  wire [BIT_W-1:0] len = len_of(fmt_r);
  wire [PS_W-1:0] ps = fmt_r[FMT_PS_LSB +: PS_W];
  wire phase = fmt_r[FMT_PHASE_BIT];
  wire pol = fmt_r[FMT_POL_BIT];
  wire [CNT_W-1:0] per_w = (ps == '0) ? PS_ZERO_PERIOD : CNT_W'({2'b00, ps}) + HOLD_EXTRA;
  wire [CNT_W-1:0] act_w = per_w >> 1;
  wire [CNT_W-1:0] idle_w = per_w - act_w;
  wire [CNT_W-1:0] n_setup = CNT_W'({2'b00, i_select_to_clock_delay}) + (hold_r ? SETUP_EXTRA_HOLD : SETUP_EXTRA);
  wire [CNT_W-1:0] n_hold = idle_w + CNT_W'({2'b00, i_clock_to_select_delay}) + HOLD_EXTRA;
  wire last_bit = (bit_r == len - BIT_W'(1));
  wire last_entry = (idx_r == last_r);

  ////////////////////////////////////////////////////////////////////////////
  // Serial clock edges, own or external
  wire din = ctrl ? i_controller_in_line : i_controller_out_line;
  wire sel_act = ctrl ? !sel_n_r : !i_select_n_pin;
  wire ext_edge = sin_r ^ sin_prev_r;
  wire ext_act = sin_r ^ pol;
  wire lead_p = ctrl ? ((st_r == ST_SETUP && cnt_r == n_setup - CNT_W'(1)) ||
                        (st_r == ST_SHIFT && !sclk_r && cnt_r == per_w - CNT_W'(1)))
                     : (st_r == ST_SHIFT && sel_act && ext_edge && ext_act);
  wire trail_p = ctrl ? (st_r == ST_SHIFT && sclk_r && cnt_r == act_w - CNT_W'(1))
                      : (st_r == ST_SHIFT && sel_act && ext_edge && !ext_act);
  wire bit_in = phase ? din : cap_r;
  wire done_w = trail_p && last_bit;
  wire hold_end = (st_r == ST_HOLD) && (cnt_r == n_hold - CNT_W'(1));
  wire [WORD_W-1:0] rx_w = sh_r & ({WORD_W{1'b1}} >> (LEN_MAX - len));
  wire [WORD_W-1:0] stat_w = STAT_DONE | (ctrl ? '0 : STAT_PERIPH);
  wire eng_wr = (st_r == ST_WRITE);
  // Engine writes back rx and status fields
  wire [FIELD_NUM-1:0] eng_mask = FIELD_NUM'((1 << FLD_RX) | (1 << FLD_STAT));
  wire [FIELD_NUM-1:0] eng_we = eng_wr ? eng_mask : '0;
  wire [ENTRY_W-1:0] eng_wdata = {stat_w, ctl_w, rx_w, tx_w};
  wire [CNT_W-1:0] cnt_nxt = (lead_p || st_r != st_nxt) ? '0 : cnt_r + CNT_W'(1);

  // Lowest numbered pending group goes first
  always_comb begin
    pick_w = '0;
    for (int g = GRP_NUM - 1; g >= 0; g--) begin
      if (pend_r[g]) begin
        pick_w = GRP_W'(g);
      end
    end
  end

  always_comb begin
    case (st_r)
      ST_IDLE: st_nxt = (|pend_r) ? ST_FETCH : ST_IDLE;
      ST_FETCH: st_nxt = ST_LOAD;
      ST_LOAD: st_nxt = ctrl ? ST_SETUP : ST_SHIFT;
      ST_SETUP: st_nxt = lead_p ? ST_SHIFT : ST_SETUP;
      ST_SHIFT: st_nxt = done_w ? (ctrl ? ST_HOLD : ST_WRITE) : ST_SHIFT;
      ST_HOLD: st_nxt = hold_end ? ST_WRITE : ST_HOLD;
      ST_WRITE: st_nxt = ST_NEXT;
      ST_NEXT: st_nxt = last_entry ? ST_IDLE : ST_FETCH;
      default: st_nxt = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multibuffer
  // Entry memory
  buffer_ram u_ram (
    .i_ref_clk(i_ref_clk),
    .i_a_we(i_host_we),
    .i_a_addr(i_host_addr),
    .i_a_wdata(i_host_wdata),
    .o_a_rdata(o_host_rdata),
    .i_b_we(eng_we),
    .i_b_addr(idx_r),
    .i_b_wdata(eng_wdata),
    .o_b_rdata(ram_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and shifter
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      st_r <= ST_IDLE;
      pend_r <= '0;
      cnt_r <= '0;
      sin_r <= 1'b0;
      sin_prev_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      // A trigger in the same cycle as the clear stays pending
      pend_r <= (pend_r & ~((st_r == ST_IDLE) ? (GRP_NUM'(1) << pick_w) : '0)) | i_grp_trig;
      cnt_r <= cnt_nxt;
      sin_r <= i_serial_clock_pin;
      sin_prev_r <= sin_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      {idx_r, last_r, grp_r, fmt_r, hold_r, sh_r, bit_r} <= '0;
      {out_r, cap_r, sclk_r, rxb_r, rxv_r, gdone_r} <= '0;
      sel_n_r <= 1'b1;
    end else begin
      rxv_r <= 1'b0;
      gdone_r <= 1'b0;
      if (st_r == ST_IDLE && |pend_r) begin
        grp_r <= pick_w;
        idx_r <= i_grp_first[pick_w];
        last_r <= i_grp_last[pick_w];
      end
      if (st_r == ST_LOAD) begin
        fmt_r <= new_fmt;
        hold_r <= ctl_w[CTL_HOLD_BIT];
        sh_r <= ld_w;
        out_r <= new_fmt[FMT_PHASE_BIT] ? out_r : ld_w[WORD_W-1];
        bit_r <= '0;
        sel_n_r <= ctrl ? 1'b0 : sel_n_r;
      end
      if (lead_p) begin
        sclk_r <= ctrl;
        out_r <= phase ? sh_r[WORD_W-1] : out_r;
        cap_r <= phase ? cap_r : din;
      end
      if (trail_p) begin
        sclk_r <= 1'b0;
        sh_r <= {sh_r[WORD_W-2:0], bit_in};
        bit_r <= bit_r + BIT_W'(1);
        out_r <= phase ? out_r : sh_r[WORD_W-2];
      end
      // Select may stay low into the next word of the same group
      if (hold_end && !(hold_r && !last_entry)) begin
        sel_n_r <= 1'b1;
      end
      if (st_r == ST_WRITE) begin
        rxb_r <= rx_w;
        rxv_r <= 1'b1;
      end
      if (st_r == ST_NEXT) begin
        gdone_r <= last_entry;
        idx_r <= last_entry ? idx_r : idx_r + ADDR_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  assign pin_in = {i_select_n_pin, i_controller_in_line, i_controller_out_line, i_serial_clock_pin};
  assign func_out = {sel_n_r, out_r, out_r, sclk_r ^ pol};
  assign func_oe_n = {!ctrl, ctrl || i_select_n_pin, !ctrl, !ctrl};
  // Pin handed to general purpose use
  for (genvar p = 0; p < PIN_NUM; p++) begin : g_pin
    assign pin_out[p] = i_gpio_en[p] ? i_gpio_out[p] : func_out[p];
    assign pin_oe_n[p] = i_gpio_en[p] ? i_gpio_oe_n[p] : func_oe_n[p];
    always_ff @(posedge i_ref_clk) begin
      gpio_in_r[p] <= i_nrst ? pin_in[p] : 1'b0;
    end
  end

  assign o_serial_clock_pin = pin_out[PIN_CLK];
  assign o_serial_clock_pin_oe_n = pin_oe_n[PIN_CLK];
  assign o_controller_out_line = pin_out[PIN_COUT];
  assign o_controller_out_line_oe_n = pin_oe_n[PIN_COUT];
  assign o_controller_in_line = pin_out[PIN_CIN];
  assign o_controller_in_line_oe_n = pin_oe_n[PIN_CIN];
  assign o_select_n_pin = pin_out[PIN_SEL];
  assign o_select_n_pin_oe_n = pin_oe_n[PIN_SEL];
  assign o_gpio_in = gpio_in_r;
  assign o_busy = (st_r != ST_IDLE);
  assign o_active_grp = grp_r;
  assign o_grp_done = gdone_r;
  assign o_rx_buffer = rxb_r;
  assign o_rx_valid = rxv_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [CNT_W-1:0] setup_cnt_r, hold_cnt_r, hi_cnt_r;
  always_ff @(posedge i_ref_clk) begin
    setup_cnt_r <= (st_r == ST_LOAD) ? '0 : setup_cnt_r + CNT_W'(st_r == ST_SETUP);
    hold_cnt_r <= trail_p ? '0 : hold_cnt_r + CNT_W'(1);
    hi_cnt_r <= sclk_r ? hi_cnt_r + CNT_W'(1) : '0;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  a_word_len: assert property (st_r == ST_WRITE |-> bit_r == len && len >= LEN_MIN && len <= LEN_MAX)
    else $error("bit count differs from word length");
  a_rx_buffer: assert property (st_r == ST_WRITE |=> o_rx_valid && o_rx_buffer == $past(rx_w))
    else $error("receive buffer not loaded");
  a_active_half: assert property (ctrl && $fell(sclk_r) |-> hi_cnt_r == act_w)
    else $error("clock high time wrong");
  a_ctrl_clock: assert property (ctrl && !i_gpio_en[PIN_CLK] |-> !o_serial_clock_pin_oe_n)
    else $error("controller not driving clock");
  a_fmt_pick: assert property (st_r == ST_LOAD |=> fmt_r == $past(new_fmt))
    else $error("word format not taken");
  a_gpio_pass: assert property (i_gpio_en[PIN_SEL] |-> o_select_n_pin == i_gpio_out[PIN_SEL])
    else $error("gpio value not on pin");
  a_grp_bound: assert property (st_r == ST_WRITE |-> idx_r <= last_r)
    else $error("entry beyond group end");
  a_zero_period: assert property (ctrl && $rose(sclk_r) && ps == '0 |=> !sclk_r ##1 (sclk_r || st_r != ST_SHIFT))
    else $error("zero prescale period wrong");
  a_idle_level: assert property (!sclk_r && !i_gpio_en[PIN_CLK] |-> o_serial_clock_pin == pol)
    else $error("clock idle level wrong");
  a_setup_wait: assert property (ctrl && $rose(sclk_r) && bit_r == '0 |-> setup_cnt_r == n_setup && !sel_n_r)
    else $error("select to clock wait wrong");
  a_hold_wait: assert property (ctrl && $rose(sel_n_r) |-> hold_cnt_r == n_hold)
    else $error("clock to select wait wrong");
  a_full_duplex: assert property (trail_p |=> sh_r[0] == $past(bit_in) && sh_r[WORD_W-1:1] == $past(sh_r[WORD_W-2:0]))
    else $error("shift step wrong");

  c_ctrl_group: cover property (ctrl && o_grp_done);
  c_periph_word: cover property (!ctrl && o_rx_valid);
  c_held_select: cover property (ctrl && hold_end && hold_r && !last_entry);
  c_zero_ps: cover property (ctrl && $rose(sclk_r) && ps == '0);
endmodule : multibuffered_serial_port

// ===== verilog/serial_port_pkg.sv
// Shared constants and types for the multibuffered serial port
package serial_port_pkg;
  localparam int WORD_W = 16;
  localparam int ENTRIES = 256;
  localparam int ADDR_W = 8;
  localparam int FIELD_NUM = 4;
  localparam int ENTRY_W = WORD_W * FIELD_NUM;
  localparam int FMT_NUM = 4;
  localparam int FMT_SEL_W = 2;
  localparam int FMT_W = 18;
  localparam int GRP_NUM = 4;
  localparam int GRP_W = 2;
  localparam int PIN_NUM = 4;
  localparam int CNT_W = 10;
  localparam int BIT_W = 5;
  localparam int PS_W = 8;
  localparam int DLY_W = 8;
  // Entry fields: transmit, receive, control, status
  localparam int FLD_TX = 0;
  localparam int FLD_RX = 1;
  localparam int FLD_CTRL = 2;
  localparam int FLD_STAT = 3;
  // Word format register layout
  localparam int FMT_LEN_LSB = 0;
  localparam int FMT_LEN_W = 5;
  localparam int FMT_PS_LSB = 8;
  localparam int FMT_PHASE_BIT = 16;
  localparam int FMT_POL_BIT = 17;
  // Per-entry control field layout
  localparam int CTL_FSEL_LSB = 0;
  localparam int CTL_HOLD_BIT = 2;
  // Per-entry status values
  localparam logic [WORD_W-1:0] STAT_DONE = 16'h0001;
  localparam logic [WORD_W-1:0] STAT_PERIPH = 16'h0002;
  localparam logic [BIT_W-1:0] LEN_MIN = 5'h02;
  localparam logic [BIT_W-1:0] LEN_MAX = 5'h10;
  // Timing counts in peripheral clock cycles
  localparam logic [CNT_W-1:0] PS_ZERO_PERIOD = 10'h002;
  localparam logic [CNT_W-1:0] SETUP_EXTRA = 10'h002;
  localparam logic [CNT_W-1:0] SETUP_EXTRA_HOLD = 10'h003;
  localparam logic [CNT_W-1:0] HOLD_EXTRA = 10'h001;
  // Pin order inside the pin vectors
  localparam int PIN_CLK = 0;
  localparam int PIN_COUT = 1;
  localparam int PIN_CIN = 2;
  localparam int PIN_SEL = 3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_LOAD, ST_SETUP, ST_SHIFT, ST_HOLD, ST_WRITE, ST_NEXT
  } state_t;
endpackage : serial_port_pkg
